/* File: logic/ncrd_defs.svh */
// constants for the configuration request decoder
`ifndef NCRD_DEFS_SVH
`define NCRD_DEFS_SVH
`define NCRD_REQ_P_UPDATE 8'h11
`define NCRD_REQ_P_PAIR 8'h12
`define NCRD_REQ_P_FRESET 8'h13
`define NCRD_REQ_P_UNPAIR 8'h14
`define NCRD_REQ_S_UPDATE 8'h19
`define NCRD_REQ_S_PAIR 8'h1A
`define NCRD_REQ_S_FRESET 8'h1B
`define NCRD_REQ_S_UNPAIR 8'h1C
`define NCRD_SEC_LSB 0
`define NCRD_GP_LSB 8
`define NCRD_LE_LSB 16
`define NCRD_SYS_LSB 24
`define NCRD_SEC_VALID 8'hD7
`define NCRD_SEC_PRIMARY_ONLY 8'h50
`define NCRD_GP_VALID 8'h17
`define NCRD_LE_VALID 8'h3F
`define NCRD_SYS_VALID 8'h30
`define NCRD_MASK_RESET 32'h0000_0000
`define NCRD_PERM_RESET 32'hFFFF_FFFF
`define NCRD_SETTING_RESET 32'h0000_0000
`endif

/* File: logic/ncrd_pkg.sv */
// types for the configuration request decoder
package ncrd_pkg;
    typedef enum logic [1:0] {
        ncrd_act_update,
        ncrd_act_pair,
        ncrd_act_freset,
        ncrd_act_unpair
    } ncrd_action_type;
    typedef enum logic [2:0] {
        ncrd_st_idle,
        ncrd_st_busy,
        ncrd_st_success,
        ncrd_st_passcode_err,
        ncrd_st_access_denied,
        ncrd_st_param_err
    } ncrd_status_type;
    typedef struct packed {
        logic [7:0] sys;
        logic [7:0] le;
        logic [7:0] gp;
        logic [7:0] sec;
    } ncrd_select_type;
endpackage : ncrd_pkg

/* File: logic/ncrd_decoder.sv */
// configuration request decoder and settings applier
// Summary of operation
// - request code carries both requesting user and request kind; decoded before acting.
// - primary user codes 11,12,13,14 mean update, pairing, factory reset, unpair.
// - secondary user codes 19,1A,1B,1C mean update, pairing, factory reset, unpair.
// - selection mask bytes: security, green-power radio, low-energy radio, system.
// - each set mask bit copies its shadow setting into the live setting.
// - any selected setting not permitted for the user rejects with access denied.
// - several selection bits may be set and all update in one request.
// - security bits 0-2 cipher keys, bit 7 secondary passcode.
// - security bits 4 and 6 accepted only from the primary user.
// - green-power bits 0,1,2,4 select tx, security, key map, protocol settings.
// - green-power bit 5 is the unpair request, never an updatable setting.
// - low-energy bits 0-5 select six settings; bits 6 and 7 reserved.
// - system bits 0 and 1 are requests, never applied as settings.
// - system bit 4 button settings, bit 5 radio settings; others reserved.
// - abort on passcode, access or parameter error; updates go busy, then success and restart; requests go straight to success.
`include "ncrd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ncrd_decoder
    import ncrd_pkg::*;
#(
    parameter int SETTING_WIDTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] request_code,
    input wire logic [31:0] update_select_mask,
    input wire logic passcode_ok,
    input wire logic [31:0] primary_permission_mask,
    input wire logic [31:0] secondary_permission_mask,
    input wire logic [32*SETTING_WIDTH-1:0] shadow_settings,
    output logic [32*SETTING_WIDTH-1:0] live_settings,
    output ncrd_status_type request_status,
    output logic pairing_frame_request,
    output logic factory_reset_request,
    output logic unpair_request,
    output logic restart
);
    // refuse a slot width that cannot hold a setting
    if (SETTING_WIDTH < 1) begin : g_bad_width
        $error("SETTING_WIDTH must be at least one");
    end

    ncrd_select_type sel;
    ncrd_select_type valid_bits;
    logic code_known;
    logic is_primary;
    ncrd_action_type action;
    logic [31:0] perm;
    logic [31:0] allowed;
    logic denied;
    logic bad_param;
    logic [31:0] apply_mask;
    logic [31:0] next_apply;

    assign sel = ncrd_select_type'(update_select_mask);
    assign valid_bits = '{sys: `NCRD_SYS_VALID, le: `NCRD_LE_VALID,
                          gp: `NCRD_GP_VALID, sec: `NCRD_SEC_VALID};

    // request code decode
    always_comb begin
        code_known = 1'b1;
        is_primary = 1'b1;
        action = ncrd_act_update;
        case (request_code)
            `NCRD_REQ_P_UPDATE: action = ncrd_act_update;
            `NCRD_REQ_P_PAIR: action = ncrd_act_pair;
            `NCRD_REQ_P_FRESET: action = ncrd_act_freset;
            `NCRD_REQ_P_UNPAIR: action = ncrd_act_unpair;
            `NCRD_REQ_S_UPDATE: begin
                is_primary = 1'b0;
                action = ncrd_act_update;
            end
            `NCRD_REQ_S_PAIR: begin
                is_primary = 1'b0;
                action = ncrd_act_pair;
            end
            `NCRD_REQ_S_FRESET: begin
                is_primary = 1'b0;
                action = ncrd_act_freset;
            end
            `NCRD_REQ_S_UNPAIR: begin
                is_primary = 1'b0;
                action = ncrd_act_unpair;
            end
            default: code_known = 1'b0;
        endcase
    end

    // permission and parameter check on the selection mask
    always_comb begin
        perm = is_primary ? primary_permission_mask : secondary_permission_mask;
        allowed = perm;
        if (!is_primary) begin
            allowed[`NCRD_SEC_LSB +: 8] = perm[`NCRD_SEC_LSB +: 8]
                & ~`NCRD_SEC_PRIMARY_ONLY;
        end
        // request bits and reserved bits are never settings
        bad_param = |(update_select_mask & ~32'(valid_bits));
        denied = |(update_select_mask & 32'(valid_bits) & ~allowed);
        next_apply = update_select_mask & 32'(valid_bits);
    end

    // request sequencing and outcome
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            request_status <= ncrd_st_idle;
            apply_mask <= `NCRD_MASK_RESET;
            pairing_frame_request <= 1'b0;
            factory_reset_request <= 1'b0;
            unpair_request <= 1'b0;
            restart <= 1'b0;
        end else begin
            pairing_frame_request <= 1'b0;
            factory_reset_request <= 1'b0;
            unpair_request <= 1'b0;
            restart <= 1'b0;
            apply_mask <= `NCRD_MASK_RESET;
            case (request_status)
                ncrd_st_busy: begin
                    request_status <= ncrd_st_success;
                    restart <= 1'b1;
                end
                default: begin
                    if (start) begin
                        if (!passcode_ok) begin
                            request_status <= ncrd_st_passcode_err;
                        end else if (!code_known) begin
                            request_status <= ncrd_st_param_err;
                        end else if (action != ncrd_act_update) begin
                            request_status <= ncrd_st_success;
                            pairing_frame_request <= (action == ncrd_act_pair);
                            factory_reset_request <= (action == ncrd_act_freset);
                            unpair_request <= (action == ncrd_act_unpair);
                        end else if (denied) begin
                            request_status <= ncrd_st_access_denied;
                        end else if (bad_param) begin
                            request_status <= ncrd_st_param_err;
                        end else begin
                            request_status <= ncrd_st_busy;
                            apply_mask <= next_apply;
                        end
                    end
                end
            endcase
        end
    end

    // per-setting copy from shadow into live
    for (genvar i = 0; i < 32; i++) begin : g_slot
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                live_settings[i*SETTING_WIDTH +: SETTING_WIDTH] <=
                    SETTING_WIDTH'(`NCRD_SETTING_RESET);
            end else if (apply_mask[i]) begin
                live_settings[i*SETTING_WIDTH +: SETTING_WIDTH] <=
                    shadow_settings[i*SETTING_WIDTH +: SETTING_WIDTH];
            end
        end
    end
endmodule : ncrd_decoder
`default_nettype wire

/* File: verif/ncrd_checker.sv */
// port assertions for the request decoder
`timescale 1ns/1ps
`default_nettype none
module ncrd_checker
    import ncrd_pkg::*;
#(parameter int SETTING_WIDTH = 32) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic [7:0] request_code,
    input wire logic [31:0] update_select_mask,
    input wire logic passcode_ok,
    input wire logic [31:0] primary_permission_mask,
    input wire logic [32*SETTING_WIDTH-1:0] live_settings,
    input wire ncrd_status_type request_status,
    input wire logic pairing_frame_request,
    input wire logic factory_reset_request,
    input wire logic unpair_request,
    input wire logic restart
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic go = start && request_status != ncrd_st_busy && passcode_ok;
    wire logic upd = go && request_code == 8'h11 && &primary_permission_mask;
    a_pair_pulse: assert property (go && request_code inside {8'h12, 8'h1A} |=>
        pairing_frame_request ##1 !pairing_frame_request) else $error("pair pulse");
    a_reset_pulse: assert property (go && request_code inside {8'h13, 8'h1B} |=>
        factory_reset_request && request_status == ncrd_st_success) else $error("reset pulse");
    a_unpair_pulse: assert property (go && request_code inside {8'h14, 8'h1C} |=>
        unpair_request) else $error("unpair pulse");
    a_bad_code: assert property (go && !((request_code & 8'hF7) inside {[8'h11:8'h14]})
        |=> request_status == ncrd_st_param_err) else $error("bad code");
    a_no_passcode: assert property (start && request_status != ncrd_st_busy && !passcode_ok
        |=> request_status == ncrd_st_passcode_err) else $error("passcode");
    a_sec_denied: assert property (go && request_code == 8'h19 && |update_select_mask[6:4]
        && !update_select_mask[5] |=> request_status == ncrd_st_access_denied) else $error("deny");
    a_request_bits: assert property (upd && |(update_select_mask & ~32'h303F_17D7)
        |=> request_status == ncrd_st_param_err) else $error("request bits");
    a_update_flow: assert property (upd && update_select_mask == 32'h303F_17D7 |=>
        request_status == ncrd_st_busy ##1 request_status == ncrd_st_success && restart)
        else $error("update flow");
    a_restart_once: assert property (restart |=> !restart) else $error("restart");
    a_live_hold: assert property (request_status != ncrd_st_busy |=>
        $stable(live_settings)) else $error("live moved");
    c_restart: cover property (restart);
    c_denied: cover property (request_status == ncrd_st_access_denied);
    c_unpair: cover property (unpair_request);
endmodule : ncrd_checker
bind ncrd_decoder ncrd_checker #(.SETTING_WIDTH(SETTING_WIDTH)) chk_u (.*);
`default_nettype wire

/* File: verif/ncrd_reader.sv */
// reader model that leaves requests in the contactless memory
`timescale 1ns/1ps
`default_nettype none
module ncrd_reader #(parameter int W = 8) (
    input wire logic clk,
    output logic start,
    output logic [7:0] request_code,
    output logic [31:0] update_select_mask,
    output logic passcode_ok,
    output logic [32*W-1:0] shadow_settings
);
    assign shadow_settings = {W{32'hC3A5_5A3C}};
    initial begin
        start = 1'b0;
        request_code = 8'h00;
        update_select_mask = 32'h0000_0000;
        passcode_ok = 1'b0;
    end
    // released code and mask fields show the inverse so a stale sample cannot pass
    task automatic send(input logic [7:0] c, input logic [31:0] m, input logic p);
        @(posedge clk);
        start <= 1'b1;
        request_code <= c;
        update_select_mask <= m;
        passcode_ok <= p;
        @(posedge clk);
        start <= 1'b0;
        request_code <= ~c;
        update_select_mask <= ~m;
    endtask : send
endmodule : ncrd_reader
`default_nettype wire

/* File: verif/tb.sv */
// testbench for the request decoder
`timescale 1ns/1ps
`default_nettype none
module tb import ncrd_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start, pok, pair, frst, unp, rs;
    logic [7:0] code;
    logic [31:0] mask;
    logic [255:0] shadow, live;
    ncrd_status_type st;
    int miscompares = 0;
    int compares = 0;
    always #10 clk = ~clk;
    ncrd_reader rd_u (.clk(clk), .start(start), .request_code(code), .update_select_mask(mask),
        .passcode_ok(pok), .shadow_settings(shadow));
    ncrd_decoder #(.SETTING_WIDTH(8)) dut_u (.clk(clk), .rstn(rstn), .start(start),
        .request_code(code), .update_select_mask(mask), .passcode_ok(pok),
        .primary_permission_mask(32'hFFFF_FFFF), .secondary_permission_mask(32'hFFFF_FFFE),
        .shadow_settings(shadow), .live_settings(live), .request_status(st),
        .pairing_frame_request(pair), .factory_reset_request(frst), .unpair_request(unp),
        .restart(rs));
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic req(input logic [7:0] c, input logic [31:0] m, input logic p);
        rd_u.send(c, m, p);
        #1;
    endtask : req
    task automatic t_update;
        logic [31:0] m = 32'h303F_17D7;
        logic [255:0] x;
        for (int i = 0; i < 32; i++)
            x[i*8+:8] = m[i] ? shadow[i*8+:8] : 8'h00;
        req(8'h11, m, 1'b1);
        chk(st === ncrd_st_busy, "not busy");
        @(posedge clk);
        #1;
        chk(st === ncrd_st_success && rs === 1'b1, "no success");
        chk(live === x, "live wrong");
    endtask : t_update
    task automatic t_sec_update;
        logic [255:0] x = live;
        x[8+:8] = shadow[8+:8];
        req(8'h19, 32'h0000_0002, 1'b1);
        chk(st === ncrd_st_busy, "secondary not busy");
        @(posedge clk);
        #1;
        chk(st === ncrd_st_success && rs === 1'b1, "secondary no success");
        chk(live === x, "secondary live wrong");
    endtask : t_sec_update
    task automatic t_codes;
        logic [7:0] c [6] = '{8'h12, 8'h13, 8'h14, 8'h1A, 8'h1B, 8'h1C};
        for (int i = 0; i < 6; i++) begin
            req(c[i], 32'h0, 1'b1);
            chk(st === ncrd_st_success, "no success");
            chk({pair, frst, unp} === 3'b100 >> (i % 3), "wrong pulse");
            chk(rs === 1'b0, "restart on request");
        end
    endtask : t_codes
    task automatic t_errors;
        logic [255:0] k = live;
        logic [7:0] c [6] = '{8'h19, 8'h19, 8'h11, 8'h11, 8'h11, 8'h15};
        logic [31:0] m [6] = '{32'h10, 32'h01, 32'h2000, 32'h0100_0000, 32'h0040_0000, 32'h01};
        for (int i = 0; i < 6; i++) begin
            req(c[i], m[i], 1'b1);
            @(posedge clk);
            #1;
            chk(st === (i < 2 ? ncrd_st_access_denied : ncrd_st_param_err), "no abort");
            chk(live === k, "live changed");
        end
        req(8'h11, 32'h01, 1'b0);
        chk(st === ncrd_st_passcode_err, "no passcode error");
    endtask : t_errors
    task automatic wrap_up;
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_sec_update();
        t_update();
        t_codes();
        t_errors();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
